/* File: core/sleep_pkg.sv */
// sleep controller constants, kind codes, states and delay classes
// assumes one clock domain; every file of the controller imports it
// Operation
// [RQ1] sleep only when enable bit is set and halt executes
// [RQ2] kind code held at halt selects the sleep state
// [RQ3] enabled interrupt wakes, stalls core four cycles after start-up
// [RQ4] register file and static memory held unchanged during sleep
// [RQ5] reset during sleep wakes to the reset vector
// [RQ6] kind 000 idle stops only core and program memory clocks
// [RQ7] in idle any enabled interrupt wakes the device
// [RQ8] enabled converter starts a conversion on entering idle or quiet state
// [RQ9] kind 001 quiet state stops io, core and program memory clocks
// [RQ10] quiet state wakes only from its listed converter and peripheral sources
// [RQ11] kind 010 power-down stops oscillator and all generated clocks
// [RQ12] power-down wakes only from resets, address match, external irqs, pin change
// [RQ13] level wake source must hold its level until recognised
// [RQ14] power-down wake waits the fuse-selected start-up delay
// [RQ15] kind 011 power-save keeps timer 2, whose enabled events wake
// [RQ16] power-save stops timer oscillator or main clock per timer 2 clocking
// [RQ17] in power-save the running synchronous clock reaches only timer 2
// [RQ18] kind 110 with crystal is standby, oscillator kept, six-cycle wake
// [RQ19] kind 111 with crystal is extended standby, six-cycle wake
// [RQ20] timer oscillator and async clock run only for asynchronous timer 2
// [RQ21] outside idle, upper external irqs wake only when level-sensitive
// [RQ22] software sets enable just before halt and clears it after waking; core model sets it with halt, clears it one cycle later
// [RQ23] reserved kinds 100 and 101 make halt a no-op
`default_nettype none

package sleep_pkg;

   // ************************************
   // kind codes
   // ************************************
   localparam logic [2:0] KIND_IDLE = 3'h0;
   localparam logic [2:0] KIND_QUIET = 3'h1;
   localparam logic [2:0] KIND_PDOWN = 3'h2;
   localparam logic [2:0] KIND_PSAVE = 3'h3;
   localparam logic [2:0] KIND_STBY = 3'h6;
   localparam logic [2:0] KIND_XSTBY = 3'h7;

   // ************************************
   // timing
   // ************************************
   localparam int STALL_CYCLES = 4;
   localparam int STANDBY_WAKE_CYCLES = 6;
   localparam int CNT_W = 16;
   localparam logic [CNT_W-1:0] STALL_LOAD = CNT_W'(STALL_CYCLES - 1);
   localparam logic [CNT_W-1:0] STANDBY_LOAD = CNT_W'(STANDBY_WAKE_CYCLES - 1);
   // domain enables out of reset: timer 2 clocks off until configured
   localparam logic [7:0] CLK_RESET = 8'hf4;

   typedef enum logic [1:0] {
      DLY_NONE = 2'b00,
      DLY_FUSE = 2'b01,
      DLY_SIX = 2'b10
   } delay_e;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_SLEEP = 2'b01,
      ST_START = 2'b10,
      ST_STALL = 2'b11
   } state_e;

endpackage

`default_nettype wire

/* File: core/sleep_kind_decode.sv */
// decodes a sleep kind code into clock enables and wake delay class
// assumes timer 2 clocking inputs are steady while sleeping
`default_nettype none

module sleep_kind_decode
   import sleep_pkg::*;
(
   input wire logic [2:0] kindCode,
   input wire logic crystalSelected,
   input wire logic timer2Enabled,
   input wire logic timer2Async,
   input wire logic timer2Sync,
   output logic kindValid,
   output logic ioEn,
   output logic convEn,
   output logic asyncEn,
   output logic mainOscEn,
   output logic timerOscEn,
   output logic t2SyncEn,
   output sleep_pkg::delay_e delayKind
);
   import sleep_pkg::*;

   wire isIdle = (kindCode == KIND_IDLE);
   wire isQuiet = (kindCode == KIND_QUIET);
   wire isSave = (kindCode == KIND_PSAVE);
   wire isStby = (kindCode == KIND_STBY);
   wire isXStby = (kindCode == KIND_XSTBY);
   wire t2AsyncOn = timer2Enabled & timer2Async;
   wire t2SyncOn = timer2Enabled & timer2Sync;
   wire keepsTimer = isIdle | isQuiet | isSave | isXStby;
   wire saveMainOn = isSave & t2SyncOn;

   // ************************************
   // validity and domain enables
   // ************************************
   assign kindValid = isIdle | isQuiet | (kindCode == KIND_PDOWN) | isSave
      | ((isStby | isXStby) & crystalSelected); // RQ23
   assign ioEn = isIdle; // RQ6
   assign convEn = isIdle | isQuiet; // RQ9
   assign asyncEn = keepsTimer & t2AsyncOn; // RQ20
   assign timerOscEn = keepsTimer & t2AsyncOn; // RQ16
   assign mainOscEn = isIdle | isQuiet | isStby | isXStby | saveMainOn; // RQ11
   assign t2SyncEn = (isQuiet | isSave | isXStby) & t2SyncOn; // RQ17
   assign delayKind = (isStby | isXStby) ? DLY_SIX :
      ((isIdle | isQuiet | saveMainOn) ? DLY_NONE : DLY_FUSE); // RQ14

endmodule

`default_nettype wire

/* File: core/wake_counter.sv */
// down counter timing the start-up delay and the core stall
// assumes load is only raised on state entry
`default_nettype none

module wake_counter
   import sleep_pkg::*;
#(
   parameter int W = 16
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic load,
   input wire logic [W-1:0] loadVal,
   output logic cntZero
);
   import sleep_pkg::*;

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;

   assign cnt_d = load ? loadVal : ((cnt_q == '0) ? cnt_q : cnt_q - W'(1));
   assign cntZero = (cnt_q == '0);

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

endmodule

`default_nettype wire

/* File: core/sleep_mode_controller.sv */
// sleep mode controller: entry on halt, clock gating, wake sequencing
// assumes wake inputs are enabled, pending requests synchronous to ref_clk
`default_nettype none

module sleep_mode_controller
   import sleep_pkg::*;
#(
   parameter int STARTUP_SHORT_CYC = 16,
   parameter int STARTUP_LONG_CYC = 16384
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic sleepEnableBit,
   input wire logic [2:0] sleepKindCode,
   input wire logic haltExec,
   input wire logic crystalSelected,
   input wire logic [3:0] clockSourceFuses,
   input wire logic converterEnabled,
   input wire logic timer2Enabled,
   input wire logic timer2Async,
   input wire logic timer2Sync,
   input wire logic [1:0] timer2IrqMask,
   input wire logic timer2Overflow,
   input wire logic timer2Compare,
   input wire logic globalIrqEnable,
   input wire logic [3:0] lowerExternalIrqs,
   input wire logic [3:0] upperIrqLevel,
   input wire logic [3:0] upperIrqEdge,
   input wire logic pinChangeIrq,
   input wire logic twoWireAddrMatch,
   input wire logic twoWireIrq,
   input wire logic converterDoneIrq,
   input wire logic storeReadyIrq,
   input wire logic watchdogIrq,
   input wire logic otherIoIrq,
   input wire logic resetReq,
   output logic coreClkEn,
   output logic programMemClkEn,
   output logic ioClkEn,
   output logic converterClkEn,
   output logic asyncTimerClkEn,
   output logic mainOscEn,
   output logic timerOscEn,
   output logic timer2SyncClkEn,
   output logic coreStall,
   output logic memoryHold,
   output logic sleeping,
   output logic convStart,
   output logic irqServe,
   output logic resetVector
);
   import sleep_pkg::*;

   // ************************************
   // state
   // ************************************
   state_e state_q;
   state_e state_d;
   logic [2:0] kind_q;
   logic [2:0] kind_d;
   logic [7:0] clk_q;
   logic [7:0] clk_d;
   logic convStart_q;
   logic irqServe_q;
   logic resetVector_q;

   // ************************************
   // mode decode
   // ************************************
   wire decValid;
   wire decIo;
   wire decConv;
   wire decAsync;
   wire decMain;
   wire decTimerOsc;
   wire decT2Sync;
   delay_e decDelay;

   // while running, decode the live code; while asleep, the latched one
   wire [2:0] decKind = (state_q == ST_RUN) ? sleepKindCode : kind_q; // RQ2

   sleep_kind_decode u_decode (
      .kindCode(decKind),
      .crystalSelected(crystalSelected),
      .timer2Enabled(timer2Enabled),
      .timer2Async(timer2Async),
      .timer2Sync(timer2Sync),
      .kindValid(decValid),
      .ioEn(decIo),
      .convEn(decConv),
      .asyncEn(decAsync),
      .mainOscEn(decMain),
      .timerOscEn(decTimerOsc),
      .t2SyncEn(decT2Sync),
      .delayKind(decDelay)
   );

   // ************************************
   // wake sources
   // ************************************
   wire isIdle = (kind_q == KIND_IDLE);
   wire isQuiet = (kind_q == KIND_QUIET);
   wire isSaveLike = (kind_q == KIND_PSAVE) | (kind_q == KIND_XSTBY);
   wire t2Event = globalIrqEnable
      & ((timer2Overflow & timer2IrqMask[0]) | (timer2Compare & timer2IrqMask[1]));
   wire extLevel = (|lowerExternalIrqs) | (|upperIrqLevel) | pinChangeIrq;
   // deep states: asynchronous sources only, upper inputs by level only
   wire deepWake = extLevel | twoWireAddrMatch; // RQ12 RQ21
   wire idleWake = deepWake | (|upperIrqEdge) | twoWireIrq | t2Event
      | storeReadyIrq | converterDoneIrq | watchdogIrq | otherIoIrq; // RQ7
   wire quietWake = deepWake | converterDoneIrq | watchdogIrq | twoWireIrq
      | (timer2Enabled & t2Event) | storeReadyIrq; // RQ10
   wire saveWake = deepWake | (timer2Enabled & t2Event); // RQ15
   wire wakeIrq = isIdle ? idleWake :
      (isQuiet ? quietWake : (isSaveLike ? saveWake : deepWake));

   // ************************************
   // start-up delay selection
   // ************************************
   wire [CNT_W-1:0] fuseLoad = clockSourceFuses[3]
      ? CNT_W'(STARTUP_LONG_CYC - 1) : CNT_W'(STARTUP_SHORT_CYC - 1); // RQ14
   wire [CNT_W-1:0] startLoad = (decDelay == DLY_SIX) ? STANDBY_LOAD : fuseLoad; // RQ18 RQ19
   wire needStart = (decDelay != DLY_NONE);

   wire cntZero;
   wire cntLoad = (state_q != state_d) & ((state_d == ST_START) | (state_d == ST_STALL));
   wire [CNT_W-1:0] cntVal = (state_d == ST_START) ? startLoad : STALL_LOAD;

   wake_counter #(
      .W(CNT_W)
   ) u_counter (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .load(cntLoad),
      .loadVal(cntVal),
      .cntZero(cntZero)
   );

   // ************************************
   // sequencing
   // ************************************
   wire enterSleep = haltExec & sleepEnableBit & decValid; // RQ1 RQ23

   always_comb begin
      state_d = state_q;
      kind_d = kind_q;
      case (state_q)
         ST_RUN: begin
            if (enterSleep) begin
               state_d = ST_SLEEP;
               kind_d = sleepKindCode; // RQ2
            end
         end
         ST_SLEEP: begin
            if (resetReq) begin
               state_d = ST_RUN; // RQ5
            end else if (wakeIrq) begin
               state_d = needStart ? ST_START : ST_STALL; // RQ3
            end
         end
         ST_START: begin
            if (resetReq) begin
               state_d = ST_RUN; // RQ5
            end else if (cntZero) begin
               state_d = ST_STALL; // RQ14
            end
         end
         ST_STALL: begin
            if (resetReq) begin
               state_d = ST_RUN; // RQ5
            end else if (cntZero) begin
               state_d = ST_RUN; // RQ3
            end
         end
         default: begin
            state_d = ST_RUN;
         end
      endcase
   end

   // ************************************
   // clock enables, ordered
   // core, program memory, io, converter, async, main osc, timer osc, t2 sync
   // ************************************
   wire runAsync = timer2Enabled & timer2Async;
   wire [7:0] runClk = {1'b1, 1'b1, 1'b1, 1'b1, runAsync, 1'b1, runAsync, 1'b0};
   wire [7:0] sleepClk = {1'b0, 1'b0, decIo, decConv, decAsync, decMain, decTimerOsc,
      decT2Sync}; // RQ6 RQ9 RQ11 RQ16 RQ17 RQ20
   // start-up restarts the oscillator, core and program memory stay stopped until stable, other domains keep their sleep enables
   wire [7:0] startClk = {1'b0, 1'b0, decIo, decConv, decAsync, 1'b1, decTimerOsc,
      decT2Sync};

   assign clk_d = ((state_d == ST_RUN) | (state_d == ST_STALL)) ? runClk :
      ((state_d == ST_START) ? startClk : sleepClk);

   wire convKind = (sleepKindCode == KIND_IDLE) | (sleepKindCode == KIND_QUIET);

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_q <= ST_RUN;
         kind_q <= 3'h0;
         clk_q <= CLK_RESET;
         convStart_q <= 1'b0;
         irqServe_q <= 1'b0;
         resetVector_q <= 1'b0;
      end else begin
         state_q <= state_d;
         kind_q <= kind_d;
         clk_q <= clk_d;
         convStart_q <= (state_q == ST_RUN) & enterSleep & convKind & converterEnabled; // RQ8
         irqServe_q <= (state_q == ST_STALL) & (state_d == ST_RUN) & ~resetReq; // RQ3
         resetVector_q <= (state_q != ST_RUN) & resetReq; // RQ5
      end
   end

   assign coreClkEn = clk_q[7];
   assign programMemClkEn = clk_q[6];
   assign ioClkEn = clk_q[5];
   assign converterClkEn = clk_q[4];
   assign asyncTimerClkEn = clk_q[3];
   assign mainOscEn = clk_q[2];
   assign timerOscEn = clk_q[1];
   assign timer2SyncClkEn = clk_q[0];
   assign coreStall = (state_q != ST_RUN);
   // blocks register file and memory writes while the core is down
   assign memoryHold = (state_q != ST_RUN); // RQ4
   assign sleeping = (state_q == ST_SLEEP);
   assign convStart = convStart_q;
   assign irqServe = irqServe_q;
   assign resetVector = resetVector_q;

   // ************************************
   // assertions
   // ************************************
   property p_noSleepWithoutEnable;
      @(posedge ref_clk) disable iff (sys_rst)
      (state_q == ST_RUN) && haltExec && !sleepEnableBit |=> state_q == ST_RUN;
   endproperty
   a_noSleepWithoutEnable: assert property (p_noSleepWithoutEnable) // RQ1
      else $error("halt without enable entered sleep");

   property p_reservedNoSleep;
      @(posedge ref_clk) disable iff (sys_rst)
      (state_q == ST_RUN) && haltExec && (sleepKindCode[2:1] == 2'b10)
         |=> (state_q == ST_RUN) && !coreStall;
   endproperty
   a_reservedNoSleep: assert property (p_reservedNoSleep) // RQ23
      else $error("reserved kind entered sleep");

   property p_kindLatched;
      @(posedge ref_clk) disable iff (sys_rst)
      (state_q == ST_RUN) && enterSleep |=> sleeping && (kind_q == $past(sleepKindCode));
   endproperty
   a_kindLatched: assert property (p_kindLatched) // RQ2
      else $error("sleep kind not taken from halt cycle");

   property p_stallFour;
      @(posedge ref_clk) disable iff (sys_rst)
      ($rose(state_q == ST_STALL) && !resetReq ##1 (!resetReq)[*3])
         |=> irqServe && (state_q == ST_RUN) && $past(coreStall, 4);
   endproperty
   a_stallFour: assert property (p_stallFour) // RQ3
      else $error("core stall after wake not four cycles");

   property p_idleGates;
      @(posedge ref_clk) disable iff (sys_rst)
      sleeping && (kind_q == KIND_IDLE)
         |-> !coreClkEn && !programMemClkEn && ioClkEn && converterClkEn && mainOscEn;
   endproperty
   a_idleGates: assert property (p_idleGates) // RQ6
      else $error("idle clock gating wrong");

   property p_quietGates;
      @(posedge ref_clk) disable iff (sys_rst)
      sleeping && (kind_q == KIND_QUIET) |-> !ioClkEn && !coreClkEn && converterClkEn;
   endproperty
   a_quietGates: assert property (p_quietGates) // RQ9
      else $error("quiet state clock gating wrong");

   property p_powerDownOff;
      @(posedge ref_clk) disable iff (sys_rst)
      sleeping && (kind_q == KIND_PDOWN)
         |-> !mainOscEn && !ioClkEn && !converterClkEn && !asyncTimerClkEn && !timerOscEn;
   endproperty
   a_powerDownOff: assert property (p_powerDownOff) // RQ11
      else $error("power-down left a clock running");

   property p_resetWake;
      @(posedge ref_clk) disable iff (sys_rst)
      sleeping && resetReq |=> resetVector && (state_q == ST_RUN) && !irqServe;
   endproperty
   a_resetWake: assert property (p_resetWake) // RQ5
      else $error("reset in sleep did not go to reset vector");

   property p_convStart;
      @(posedge ref_clk) disable iff (sys_rst)
      (state_q == ST_RUN) && enterSleep && converterEnabled && convKind |=> convStart;
   endproperty
   a_convStart: assert property (p_convStart) // RQ8
      else $error("conversion not started on sleep entry");

   property p_standbySix;
      @(posedge ref_clk) disable iff (sys_rst)
      (sleeping && (kind_q[2:1] == 2'b11) && wakeIrq && !resetReq ##1 (!resetReq)[*6])
         |=> (state_q == ST_STALL) && $past(state_q == ST_START, 6);
   endproperty
   a_standbySix: assert property (p_standbySix) // RQ18
      else $error("standby wake not six cycles");

   property p_upperEdgeIgnored;
      @(posedge ref_clk) disable iff (sys_rst)
      sleeping && !isIdle && !resetReq && (|upperIrqEdge) && !(|upperIrqLevel)
         && !(|lowerExternalIrqs) && !pinChangeIrq && !twoWireAddrMatch && !t2Event
         && !twoWireIrq && !converterDoneIrq && !storeReadyIrq && !watchdogIrq
         |=> state_q == ST_SLEEP;
   endproperty
   a_upperEdgeIgnored: assert property (p_upperEdgeIgnored) // RQ21
      else $error("edge on upper irq woke a deep state");

   property p_syncOnlyTimer2;
      @(posedge ref_clk) disable iff (sys_rst)
      sleeping && (kind_q == KIND_PSAVE) && timer2Enabled && timer2Sync
         |-> mainOscEn && timer2SyncClkEn && !ioClkEn && !converterClkEn;
   endproperty
   a_syncOnlyTimer2: assert property (p_syncOnlyTimer2) // RQ17
      else $error("power-save sync clock leaked");

   property p_memoryHeld;
      @(posedge ref_clk) disable iff (sys_rst)
      sleeping |-> memoryHold && coreStall && !coreClkEn && !programMemClkEn;
   endproperty
   a_memoryHeld: assert property (p_memoryHeld) // RQ4
      else $error("memory not held while asleep");

endmodule

`default_nettype wire

/* File: bench/core_model.sv */
// core model: sets the enable bit, executes halt, counts resumes
// assumes halt commands are one cycle wide and synchronous to ref_clk
`default_nettype none

module core_model (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic haltCmd,
   input wire logic useEn,
   input wire logic irqServe,
   input wire logic resetVector,
   output logic sleepEnableBit,
   output logic haltExec,
   output int wakes
);
   timeunit 1ns;
   timeprecision 1ps;

   // ****************
   // halt issue
   // ****************
   // enable only in the halt cycle, so a stray halt never sleeps
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sleepEnableBit <= 1'b0;
         haltExec <= 1'b0;
         wakes <= 0;
      end else begin
         haltExec <= haltCmd;
         sleepEnableBit <= haltCmd & useEn;
         if (irqServe | resetVector) begin
            wakes <= wakes + 1;
         end
      end
   end
endmodule

`default_nettype wire

/* File: bench/test_sleep_mode_controller.sv */
// bench for the sleep controller: entry, gating, wake sources, wake timing
// assumes the core model in core_model.sv; wake sources driven here
`default_nettype none

module test_sleep_mode_controller;
   timeunit 1ns;
   timeprecision 1ps;
   import sleep_pkg::*;
   localparam int SHORT = 3;
   localparam int LONG = 8;
   logic ref_clk, sys_rst, haltCmd, useEn, crystalSelected, converterEnabled;
   logic timer2Enabled, timer2Async, timer2Sync, globalIrqEnable, resetReq;
   logic [2:0] sleepKindCode;
   logic [3:0] clockSourceFuses;
   logic [1:0] timer2IrqMask, lineSel;
   logic [10:0] src;
   logic sleepEnableBit, haltExec, coreClkEn, programMemClkEn, ioClkEn, converterClkEn;
   logic asyncTimerClkEn, mainOscEn, timerOscEn, timer2SyncClkEn, coreStall, memoryHold;
   logic sleeping, convStart, irqServe, resetVector;
   int wakes, err_total, n_checks, cyc, expWakes;

   sleep_mode_controller #(.STARTUP_SHORT_CYC(SHORT), .STARTUP_LONG_CYC(LONG))
   sleep_mode_controller_inst (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .sleepEnableBit(sleepEnableBit),
      .sleepKindCode(sleepKindCode), .haltExec(haltExec), .crystalSelected(crystalSelected),
      .clockSourceFuses(clockSourceFuses), .converterEnabled(converterEnabled),
      .timer2Enabled(timer2Enabled), .timer2Async(timer2Async), .timer2Sync(timer2Sync),
      .timer2IrqMask(timer2IrqMask), .timer2Overflow(src[10]), .timer2Compare(src[10]),
      .globalIrqEnable(globalIrqEnable), .lowerExternalIrqs(4'(src[0]) << lineSel),
      .upperIrqLevel(4'(src[1]) << lineSel), .upperIrqEdge(4'(src[2]) << lineSel),
      .pinChangeIrq(src[3]), .twoWireAddrMatch(src[4]), .twoWireIrq(src[5]),
      .converterDoneIrq(src[6]), .storeReadyIrq(src[7]), .watchdogIrq(src[8]),
      .otherIoIrq(src[9]), .resetReq(resetReq), .coreClkEn(coreClkEn),
      .programMemClkEn(programMemClkEn), .ioClkEn(ioClkEn), .converterClkEn(converterClkEn),
      .asyncTimerClkEn(asyncTimerClkEn), .mainOscEn(mainOscEn), .timerOscEn(timerOscEn),
      .timer2SyncClkEn(timer2SyncClkEn), .coreStall(coreStall), .memoryHold(memoryHold),
      .sleeping(sleeping), .convStart(convStart), .irqServe(irqServe),
      .resetVector(resetVector));

   core_model core_model_inst (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .haltCmd(haltCmd), .useEn(useEn),
      .irqServe(irqServe), .resetVector(resetVector), .sleepEnableBit(sleepEnableBit),
      .haltExec(haltExec), .wakes(wakes));

   // ****************
   // expectations
   // ****************
   // order: core, program memory, io, converter, async, main osc, timer osc
   function automatic logic [6:0] exp_clk(input logic [2:0] k);
      logic a;
      a = timer2Enabled & timer2Async;
      case (k)
         3'h0: exp_clk = {4'h3, a, 1'b1, a};
         3'h1: exp_clk = {4'h1, a, 1'b1, a};
         3'h3: exp_clk = {4'h0, a, timer2Enabled & timer2Sync, a};
         3'h6: exp_clk = 7'h02;
         3'h7: exp_clk = {4'h0, a, 1'b1, a};
         default: exp_clk = 7'h00;
      endcase
   endfunction

   function automatic int exp_lat(input logic [2:0] k);
      int n;
      n = clockSourceFuses[3] ? LONG : SHORT;
      if (k == 3'h3 && timer2Enabled && timer2Sync) n = 0;
      if (k < 3'h2) n = 0;
      if (k > 3'h5) n = STANDBY_WAKE_CYCLES;
      exp_lat = n + STALL_CYCLES;
   endfunction

   function automatic logic [10:0] wake_ok(input logic [2:0] k);
      case (k)
         3'h0: wake_ok = 11'h7ff;
         3'h1: wake_ok = 11'h5fb;
         3'h3, 3'h7: wake_ok = 11'h41b;
         default: wake_ok = 11'h01b;
      endcase
   endfunction

   // ****************
   // checks
   // ****************
   task automatic chk_bit(input string what, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %b seen %b", what, e, g);
      end
   endtask

   task automatic chk_vec(input string what, input logic [6:0] e, input logic [6:0] g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %b seen %b", what, e, g);
      end
   endtask

   task automatic chk_num(input string what, input int e, input int g);
      n_checks++;
      if (g != e) begin
         err_total++;
         $display("ERROR %s expected %0d seen %0d", what, e, g);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ****************
   // one sleep cycle
   // ****************
   task automatic run_one(input logic [2:0] k, input logic x, input logic en);
      logic ok;
      logic [10:0] m;
      int id, n, mode;
      ok = en && (k < 3'h4 || (k > 3'h5 && x));
      @(posedge ref_clk);
      sleepKindCode <= k;
      crystalSelected <= x;
      useEn <= en;
      haltCmd <= 1'b1;
      {timer2Enabled, timer2Async, timer2Sync, converterEnabled} <= 4'($urandom);
      clockSourceFuses <= 4'($urandom);
      timer2IrqMask <= 2'($urandom % 3 + 1);
      lineSel <= 2'($urandom);
      @(posedge ref_clk);
      haltCmd <= 1'b0;
      @(posedge ref_clk);
      #1;
      chk_bit("sleeping", ok, sleeping);
      if (!ok) begin
         chk_bit("coreClkEn", 1'b1, coreClkEn);
      end else begin
         chk_vec("clocks", exp_clk(k), {coreClkEn, programMemClkEn, ioClkEn, converterClkEn,
            asyncTimerClkEn, mainOscEn, timerOscEn});
         if (k[1]) chk_bit("t2sync", k[0] & timer2Enabled & timer2Sync, timer2SyncClkEn);
         chk_bit("convStart", converterEnabled & ~k[1] & ~k[2], convStart);
         chk_bit("memoryHold", 1'b1, memoryHold);
         m = wake_ok(k);
         id = $urandom % 11;
         if (!m[id]) begin
            @(posedge ref_clk);
            src[id] <= 1'b1;
            @(posedge ref_clk);
            src[id] <= 1'b0;
            @(posedge ref_clk);
            #1;
            chk_bit("ignored", 1'b1, sleeping);
         end
         id = $urandom % 11;
         if (!m[id] || (id == 10 && !timer2Enabled)) id = 3;
         mode = $urandom % 4;
         @(posedge ref_clk);
         if (mode == 0) resetReq <= 1'b1;
         else src[id] <= 1'b1;
         @(posedge ref_clk);
         resetReq <= 1'b0;
         src <= 11'h0;
         #1;
         n = 0;
         while (mode != 0 && irqServe !== 1'b1 && resetVector !== 1'b1 && n < 40) begin
            @(posedge ref_clk);
            resetReq <= (mode == 1 && n == 1);
            n++;
            #1;
         end
         if (mode < 2) chk_bit("resetVector", 1'b1, resetVector);
         else chk_num("latency", exp_lat(k), n);
         expWakes++;
         @(posedge ref_clk);
         #1;
         chk_bit("pulse", 1'b0, irqServe | resetVector);
         chk_bit("coreStall", 1'b0, coreStall);
      end
      $display("test kind %0d xtal %0d en %0d done", k, x, en);
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 8000) begin
         err_total++;
         $display("ERROR timeout expected done seen hang");
         print_verdict();
      end
   end

   initial begin
      {sys_rst, haltCmd, useEn, crystalSelected, converterEnabled, resetReq} = 6'h20;
      {timer2Enabled, timer2Async, timer2Sync, globalIrqEnable} = 4'h1;
      sleepKindCode = 3'h0;
      clockSourceFuses = 4'h0;
      timer2IrqMask = 2'h1;
      lineSel = 2'h0;
      src = 11'h0;
      void'($urandom(32'h6899));
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      for (int k = 0; k < 8; k++) run_one(3'(k), 1'b1, 1'b1);
      run_one(3'h6, 1'b0, 1'b1);
      run_one(3'h7, 1'b0, 1'b1);
      run_one(3'h0, 1'b1, 1'b0);
      repeat (60) run_one(3'($urandom), 1'($urandom), ($urandom % 8) != 0);
      @(posedge ref_clk);
      #1;
      chk_num("wakes", expWakes, wakes);
      // system reset while asleep, then a first halt right after release
      @(posedge ref_clk);
      sleepKindCode <= 3'h2;
      useEn <= 1'b1;
      haltCmd <= 1'b1;
      @(posedge ref_clk);
      haltCmd <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk_bit("sleeping", 1'b1, sleeping);
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      expWakes = 0;
      #1;
      chk_bit("rstSleeping", 1'b0, sleeping);
      chk_bit("rstCoreClk", 1'b1, coreClkEn);
      chk_bit("rstAsync", 1'b0, asyncTimerClkEn);
      run_one(3'h1, 1'b1, 1'b1);
      @(posedge ref_clk);
      #1;
      chk_num("wakes", expWakes, wakes);
      print_verdict();
   end
endmodule

`default_nettype wire
